// ==== src/pgr_delay.sv ====
// Purpose: Counts slow clock ticks while a condition holds
// Assumes: tick is a one-cycle pulse per slow period
// Notes: done drops in the cycle after cond falls

`timescale 1ns/1ps

module pgr_delay
   import pgr_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   pgr_dly_if.tmr dly
);
   pgr_cnt_t cnt, next_cnt;
   logic done_q, next_done;

   always_comb begin
      next_cnt = cnt;
      next_done = 1'h0;
      if (!dly.cond) begin
         next_cnt = '0;
      end else if (cnt >= dly.limit) begin
         next_done = 1'h1;
      end else if (dly.tick) begin
         next_cnt = cnt + 1'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt <= '0;
         done_q <= 1'h0;
      end else begin
         cnt <= next_cnt;
         done_q <= next_done;
      end
   end

   assign dly.done = done_q;

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (srst);

   done_cause_a: assert property ($rose(done_q) |-> $past(dly.cond) && $past(cnt) >= $past(dly.limit))
      else $error("delay done without full count");
   done_drop_a: assert property (!dly.cond |=> !done_q && cnt == '0)
      else $error("delay done held after condition fell");
endmodule // pgr_delay

// ==== src/pgr_dly_if.sv ====
// Purpose: Carries one delay request between the controller and a timer
// Assumes: All signals on core_clk
// Notes: Timer output done is a level

`timescale 1ns/1ps

interface pgr_dly_if;
   logic cond;
   logic tick;
   pgr_pkg::pgr_cnt_t limit;
   logic done;
   modport ctrl (output cond, output tick, output limit, input done);
   modport tmr (input cond, input tick, input limit, output done);
endinterface

// ==== src/pgr_pkg.sv ====
// Purpose: Shared constants for the power-good and reset control block
// Assumes: Delays are counted in slow real-time clock periods
// Notes: Offsets are the byte addresses seen over the serial bus

package pgr_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_PGD = 8'h40;
   localparam logic [7:0] OFF_SLEEP_ENABLE_CTRL = 8'h41;
   localparam logic [7:0] OFF_LOCK = 8'h42;
   localparam logic [7:0] OFF_PMASK = 8'h43;
   localparam logic [7:0] OFF_RSTC = 8'h48;
   localparam logic [7:0] OFF_FORCED_SHUTDOWN = 8'h49;

   // ----------------------------------------
   // Reset values and field positions
   // ----------------------------------------
   localparam logic [6:0] PGD_RST = 7'h5f;
   localparam logic [7:0] SLEEP_ENABLE_CTRL_RST = 8'h00;
   localparam logic LOCK_RST = 1'h0;
   localparam logic [7:0] PMASK_RST = 8'h00;
   localparam logic [4:0] RSTC_RST = 5'h1c;
   localparam int PGD_RES_LSB = 5;
   localparam int PGD_PLT_LSB = 3;
   localparam int RSTC_TRST_LSB = 3;
   localparam int SLEEP_ENABLE_CTRL_S4_BIT = 1;
   localparam int SLEEP_ENABLE_CTRL_DS_BIT = 0;

   // ----------------------------------------
   // Timing in slow clock periods
   // ----------------------------------------
   localparam int CNT_W = 13;
   typedef logic [CNT_W-1:0] pgr_cnt_t;
   localparam int RTC_PERIOD_NS = 30500;
   localparam int TRST0_MS = 20;
   localparam int TRST1_MS = 40;
   localparam int TRST2_MS = 80;
   localparam int TRST3_MS = 200;
   localparam pgr_cnt_t DLY_0 = 13'h000;
   localparam pgr_cnt_t DLY_82 = 13'h052;
   localparam pgr_cnt_t DLY_164 = 13'h0a4;
   localparam pgr_cnt_t DLY_328 = 13'h148;
   localparam pgr_cnt_t DLY_360 = 13'h168;
   localparam pgr_cnt_t DLY_492 = 13'h1ec;
   localparam pgr_cnt_t DLY_656 = 13'h290;
   localparam pgr_cnt_t DLY_721 = 13'h2d1;
   localparam pgr_cnt_t DLY_1640 = 13'h668;
   localparam pgr_cnt_t DLY_2460 = 13'h99c;
   localparam pgr_cnt_t DLY_3280 = 13'hcd0;

   // Least time, so round up to whole slow periods
   function automatic pgr_cnt_t pgr_ms_ticks(input int ms);
      return pgr_cnt_t'((ms * 1000000 + RTC_PERIOD_NS - 1) / RTC_PERIOD_NS);
   endfunction

   function automatic pgr_cnt_t pgr_resume_cnt(input logic [1:0] code);
      case (code)
         2'h0: return DLY_0;
         2'h1: return DLY_164;
         2'h2: return DLY_360;
         default: return DLY_721;
      endcase
   endfunction

   function automatic pgr_cnt_t pgr_plat_cnt(input logic [1:0] code);
      case (code)
         2'h0: return DLY_82;
         2'h1: return DLY_164;
         2'h2: return DLY_328;
         default: return DLY_656;
      endcase
   endfunction

   function automatic pgr_cnt_t pgr_sys_cnt(input logic [2:0] code);
      case (code)
         3'h0: return DLY_82;
         3'h1: return DLY_164;
         3'h2: return DLY_328;
         3'h3: return DLY_492;
         3'h4: return DLY_656;
         3'h5: return DLY_1640;
         3'h6: return DLY_2460;
         default: return DLY_3280;
      endcase
   endfunction

   function automatic pgr_cnt_t pgr_trst_cnt(input logic [1:0] code);
      case (code)
         2'h0: return pgr_ms_ticks(TRST0_MS);
         2'h1: return pgr_ms_ticks(TRST1_MS);
         2'h2: return pgr_ms_ticks(TRST2_MS);
         default: return pgr_ms_ticks(TRST3_MS);
      endcase
   endfunction

endpackage

// ==== src/pgr_sync_edge.sv ====
// Purpose: Two-stage synchroniser with edge pulses
// Assumes: async_in is from outside the core_clk domain
// Notes: Edges are one-cycle pulses, aligned with level

`timescale 1ns/1ps

module pgr_sync_edge #(
   parameter logic INIT = 1'h0
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta, sync, next_rise, next_fall;

   always_comb begin
      next_rise = sync & ~level;
      next_fall = ~sync & level;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta <= INIT;
         sync <= INIT;
         level <= INIT;
         rise <= 1'h0;
         fall <= 1'h0;
      end else begin
         meta <= async_in;
         sync <= meta;
         level <= sync;
         rise <= next_rise;
         fall <= next_fall;
      end
   end
endmodule // pgr_sync_edge

// ==== src/pgr_top.sv ====
// Purpose: Power-good sequencing and reset control registers behind a serial slave
// Assumes: scl, sda_in, rtc_clk and status pins are asynchronous to core_clk
// Notes: rtc_srst resets only the always-powered register

`timescale 1ns/1ps

module pgr_top
   import pgr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary default
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic rtc_srst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic rtc_clk,
   input wire logic always_on_good,
   input wire logic all_rails_good,
   input wire logic supply_low,
   input wire logic [7:0] rail_enable_pin,
   input wire logic [7:0] regulator_voltage_ctrl,
   output logic resume_reset_good,
   output logic platform_hub_power_ok,
   output logic system_power_ok,
   output logic system_reset,
   output logic [2:0] reset_threshold_sel,
   output logic regulator_ctrl_lock,
   output logic controller_sleep_s4_enable,
   output logic controller_deep_sleep_enable,
   output logic [7:0] regulator_enable
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [10:0] pin_meta, pin_sync;
   logic scl_lvl, scl_rise, scl_fall;
   logic sda_lvl, sda_rise, sda_fall;
   logic rtc_tick;
   logic aon_s, all_s, low_s;
   logic [7:0] pin_en_s;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {always_on_good, all_rails_good, supply_low, rail_enable_pin};
         pin_sync <= pin_meta;
      end
   end

   assign {aon_s, all_s, low_s, pin_en_s} = pin_sync;

   pgr_sync_edge #(.INIT(1'h1)) u_scl (
      .core_clk(core_clk), .srst(srst), .async_in(scl),
      .level(scl_lvl), .rise(scl_rise), .fall(scl_fall)
   );
   pgr_sync_edge #(.INIT(1'h1)) u_sda (
      .core_clk(core_clk), .srst(srst), .async_in(sda_in),
      .level(sda_lvl), .rise(sda_rise), .fall(sda_fall)
   );
   // A rising edge of the slow clock marks one period
   pgr_sync_edge #(.INIT(1'h0)) u_rtc (
      .core_clk(core_clk), .srst(srst), .async_in(rtc_clk),
      .level(), .rise(rtc_tick), .fall()
   );

   // ----------------------------------------
   // Serial slave
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
      ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
   } pgr_i2c_e;

   pgr_i2c_e state, next_state;
   logic [2:0] bitcnt, next_bitcnt;
   logic [7:0] shreg, next_shreg, ptr, next_ptr;
   logic rw, next_rw, mack, next_mack, sda_drv, next_sda_drv;
   logic start_det, stop_det, wr_fire;
   logic [7:0] wr_byte, rd_data;

   // Our sda moves only as scl is seen to fall; count only edges with scl already high
   assign start_det = sda_fall & scl_lvl & ~scl_rise;
   assign stop_det = sda_rise & scl_lvl & ~scl_rise;
   assign wr_byte = {shreg[6:0], sda_lvl};
   assign wr_fire = (state == ST_WR) & scl_rise & (bitcnt == 3'h7);

   always_comb begin
      next_state = state;
      next_bitcnt = bitcnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_rw = rw;
      next_mack = mack;
      next_sda_drv = sda_drv;
      if (start_det) begin
         next_state = ST_ADDR;
         next_bitcnt = 3'h0;
         next_sda_drv = 1'h0;
      end else if (stop_det) begin
         next_state = ST_IDLE;
         next_sda_drv = 1'h0;
      end else begin
         case (state)
            ST_ADDR, ST_PTR, ST_WR: begin
               if (scl_rise) begin
                  next_shreg = wr_byte;
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     if (state == ST_ADDR) begin
                        next_state = ST_ACK_ADDR;
                     end else if (state == ST_PTR) begin
                        next_state = ST_ACK_PTR;
                     end else begin
                        next_state = ST_ACK_WR;
                        next_ptr = ptr + 8'h01;
                     end
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WR: begin
               if (scl_fall && bitcnt == 3'h0) begin
                  if (state == ST_ACK_ADDR && shreg[7:1] != DEV_ADDR) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_sda_drv = 1'h1;
                     next_bitcnt = 3'h1;
                     if (state == ST_ACK_ADDR) begin
                        next_rw = shreg[0];
                     end
                  end
               end else if (scl_fall) begin
                  next_sda_drv = 1'h0;
                  next_bitcnt = 3'h0;
                  if (state == ST_ACK_PTR) begin
                     next_ptr = shreg;
                     next_state = ST_WR;
                  end else if (state == ST_ACK_WR) begin
                     next_state = ST_WR;
                  end else if (rw) begin
                     next_state = ST_RD;
                     next_shreg = rd_data;
                     next_ptr = ptr + 8'h01;
                     next_sda_drv = ~rd_data[7];
                  end else begin
                     next_state = ST_PTR;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall && bitcnt == 3'h7) begin
                  next_sda_drv = 1'h0;
                  next_bitcnt = 3'h0;
                  next_state = ST_ACK_RD;
               end else if (scl_fall) begin
                  next_bitcnt = bitcnt + 3'h1;
                  next_shreg = {shreg[6:0], 1'h0};
                  next_sda_drv = ~shreg[6];
               end
            end
            ST_ACK_RD: begin
               if (scl_rise) begin
                  next_mack = ~sda_lvl;
               end else if (scl_fall && mack) begin
                  next_state = ST_RD;
                  next_shreg = rd_data;
                  next_ptr = ptr + 8'h01;
                  next_sda_drv = ~rd_data[7];
               end else if (scl_fall) begin
                  next_state = ST_IDLE;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         bitcnt <= 3'h0;
         shreg <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'h0;
         mack <= 1'h0;
         sda_drv <= 1'h0;
      end else begin
         state <= next_state;
         bitcnt <= next_bitcnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         rw <= next_rw;
         mack <= next_mack;
         sda_drv <= next_sda_drv;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'h0;
   assign sda_oe = sda_drv;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   pgr_dly_if res_if ();
   pgr_dly_if plt_if ();
   pgr_dly_if sys_if ();
   pgr_dly_if rst_if ();
   logic [6:0] pgd, next_pgd;
   logic [7:0] sleep_enable_ctrl, next_sleep_enable_ctrl, pmask, next_pmask;
   logic lock, next_lock, forced_shutdown, next_forced_shutdown;
   logic hold, next_hold;
   logic [7:0] next_ren;
   logic [4:0] rstc, next_rstc;

   always_comb begin
      next_pgd = pgd;
      next_sleep_enable_ctrl = sleep_enable_ctrl;
      next_lock = lock;
      next_pmask = pmask;
      next_forced_shutdown = 1'h0;
      if (wr_fire) begin
         if (ptr == OFF_PGD) begin
            next_pgd = wr_byte[6:0];
         end else if (ptr == OFF_SLEEP_ENABLE_CTRL) begin
            next_sleep_enable_ctrl = wr_byte;
         end else if (ptr == OFF_LOCK) begin
            next_lock = wr_byte[0];
         end else if (ptr == OFF_PMASK) begin
            next_pmask = wr_byte;
         end else if (ptr == OFF_FORCED_SHUTDOWN) begin
            next_forced_shutdown = wr_byte[0];
         end
      end
      // Restart the hold on every trigger so it always lasts a full period
      if (forced_shutdown || low_s) begin
         next_hold = 1'h1;
      end else if (rst_if.done) begin
         next_hold = 1'h0;
      end else begin
         next_hold = hold;
      end
      next_ren = (pmask & regulator_voltage_ctrl) | (~pmask & pin_en_s);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pgd <= PGD_RST;
         sleep_enable_ctrl <= SLEEP_ENABLE_CTRL_RST;
         lock <= LOCK_RST;
         pmask <= PMASK_RST;
         forced_shutdown <= 1'h0;
         hold <= 1'h0;
         regulator_enable <= 8'h00;
      end else begin
         pgd <= next_pgd;
         sleep_enable_ctrl <= next_sleep_enable_ctrl;
         lock <= next_lock;
         pmask <= next_pmask;
         forced_shutdown <= next_forced_shutdown;
         hold <= next_hold;
         regulator_enable <= next_ren;
      end
   end

   // Always-powered register: system reset does not touch it
   always_comb begin
      next_rstc = rstc;
      if (wr_fire && ptr == OFF_RSTC) begin
         next_rstc = wr_byte[4:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rtc_srst) begin
         rstc <= RSTC_RST;
      end else begin
         rstc <= next_rstc;
      end
   end

   always_comb begin
      if (ptr == OFF_PGD) begin
         rd_data = {1'h0, pgd};
      end else if (ptr == OFF_SLEEP_ENABLE_CTRL) begin
         rd_data = sleep_enable_ctrl;
      end else if (ptr == OFF_LOCK) begin
         rd_data = {7'h00, lock};
      end else if (ptr == OFF_PMASK) begin
         rd_data = pmask;
      end else if (ptr == OFF_RSTC) begin
         rd_data = {3'h0, rstc};
      end else begin
         rd_data = 8'h00;
      end
   end

   assign controller_sleep_s4_enable = sleep_enable_ctrl[SLEEP_ENABLE_CTRL_S4_BIT];
   assign controller_deep_sleep_enable = sleep_enable_ctrl[SLEEP_ENABLE_CTRL_DS_BIT];
   assign regulator_ctrl_lock = lock;
   assign reset_threshold_sel = rstc[2:0];
   assign system_reset = hold;

   // ----------------------------------------
   // Delay timers
   // ----------------------------------------
   assign res_if.cond = aon_s;
   assign res_if.tick = rtc_tick;
   assign res_if.limit = pgr_resume_cnt(pgd[PGD_RES_LSB +: 2]);
   assign plt_if.cond = all_s;
   assign plt_if.tick = rtc_tick;
   assign plt_if.limit = pgr_plat_cnt(pgd[PGD_PLT_LSB +: 2]);
   assign sys_if.cond = all_s;
   assign sys_if.tick = rtc_tick;
   assign sys_if.limit = pgr_sys_cnt(pgd[2:0]);
   assign rst_if.cond = hold & ~forced_shutdown & ~low_s;
   assign rst_if.tick = rtc_tick;
   assign rst_if.limit = pgr_trst_cnt(rstc[RSTC_TRST_LSB +: 2]);

   pgr_delay u_res (.core_clk(core_clk), .srst(srst), .dly(res_if.tmr));
   pgr_delay u_plt (.core_clk(core_clk), .srst(srst), .dly(plt_if.tmr));
   pgr_delay u_sys (.core_clk(core_clk), .srst(srst), .dly(sys_if.tmr));
   pgr_delay u_rst (.core_clk(core_clk), .srst(srst), .dly(rst_if.tmr));

   assign resume_reset_good = res_if.done;
   assign platform_hub_power_ok = plt_if.done;
   assign system_power_ok = sys_if.done;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cc @(posedge core_clk); endclocking
   default disable iff (srst);

   pgd_reset_a: assert property ($past(srst) |-> pgd == PGD_RST && sleep_enable_ctrl == SLEEP_ENABLE_CTRL_RST)
      else $error("delay register wrong after reset");
   res_limit_a: assert property ($rose(resume_reset_good) |-> $past(aon_s))
      else $error("resume good rose without source");
   plt_drop_a: assert property (!all_s |=> !platform_hub_power_ok)
      else $error("platform ok held without rails good");
   sys_order_a: assert property ($rose(system_power_ok)
      && pgr_sys_cnt(pgd[2:0]) >= pgr_plat_cnt(pgd[PGD_PLT_LSB +: 2]) |-> platform_hub_power_ok)
      else $error("system ok before platform ok");
   sleep_enable_ctrl_hold_a: assert property (!wr_fire |=> $stable(sleep_enable_ctrl) && $stable(lock))
      else $error("enable register changed without write");
   lock_write_a: assert property (wr_fire && ptr == OFF_LOCK
      |=> regulator_ctrl_lock == $past(wr_byte[0]))
      else $error("lock bit did not take write");
   pin_mask_a: assert property (1'h1 |=> regulator_enable
      == (($past(pmask) & $past(regulator_voltage_ctrl)) | (~$past(pmask) & $past(pin_en_s))))
      else $error("regulator enable not per mask");
   forced_shutdown_pulse_a: assert property (forced_shutdown |=> !forced_shutdown ##1 system_reset)
      else $error("forced shutdown not one pulse into reset");
   hold_start_a: assert property (forced_shutdown |=> system_reset [*2])
      else $error("reset hold did not start");
   rtc_keep_a: assert property (@(posedge core_clk) disable iff (rtc_srst)
      !(wr_fire && ptr == OFF_RSTC) |=> $stable(rstc))
      else $error("always-powered register changed");
   rsvd_zero_a: assert property (ptr == OFF_RSTC |-> rd_data[7:5] == 3'h0)
      else $error("reserved bits not zero");

   res_rise_c: cover property ($rose(resume_reset_good));
   sys_rise_c: cover property ($rose(system_power_ok));
   reset_end_c: cover property ($fell(system_reset));
   reg_write_c: cover property (wr_fire && ptr == OFF_PMASK);
endmodule // pgr_top

// ==== tb/pgr_ec_model.sv ====
// Purpose: Controller model, serial bus master for register access
// Assumes: Data line is open drain with a pull-up, resolved in the bench
// Notes: Serial clock stands high between frames, period 64 ns
`timescale 1ns/1ps
module pgr_ec_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   localparam time Q = 16ns;
   logic [6:0] dev = ADDR;
   logic nak = 1'h0;
   initial begin
      scl = 1'h1;
      sda_pull = 1'h0;
   end
   // Data changes only mid-way through clock low, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      #Q sda_pull = !b;
      #Q scl = 1'h1;
      #(2*Q) r = sda;
      scl = 1'h0;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic m, input logic chk,
                       output logic [7:0] rx);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(m, a);
      if (chk) begin
         nak = nak | a;
      end
   endtask
   task automatic start();
      #Q sda_pull = 1'h0;
      #Q scl = 1'h1;
      #Q sda_pull = 1'h1;
      #Q scl = 1'h0;
   endtask
   task automatic stop();
      #Q sda_pull = 1'h1;
      #Q scl = 1'h1;
      #Q sda_pull = 1'h0;
      #(4*Q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      nak = 1'h0;
      start();
      xfer({dev, 1'h0}, 1'h1, 1'h1, x);
      xfer(a, 1'h1, 1'h1, x);
      xfer(d, 1'h1, 1'h1, x);
      stop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] x;
      nak = 1'h0;
      start();
      xfer({dev, 1'h0}, 1'h1, 1'h1, x);
      xfer(a, 1'h1, 1'h1, x);
      start();
      xfer({dev, 1'h1}, 1'h1, 1'h1, x);
      xfer(8'hff, 1'h1, 1'h0, d);
      stop();
   endtask
endmodule // pgr_ec_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the power-good and reset control block
// Assumes: Slow clock runs at 48 ns so long delays stay short
// Notes: One slow period is six core cycles
`timescale 1ns/1ps
module tb_top;
   import pgr_pkg::*;
   localparam int TK = 6;
   logic core_clk = 1'h0;
   logic rtc_clk = 1'h0;
   logic srst = 1'h1;
   logic rtc_srst = 1'h1;
   logic always_on_good = 1'h0;
   logic all_rails_good = 1'h0;
   logic [7:0] rail_enable_pin = 8'h3c;
   logic [7:0] regulator_voltage_ctrl = 8'h81;
   logic scl, sda_pull, sda, sda_out, sda_oe, system_reset, regulator_ctrl_lock;
   logic resume_reset_good, platform_hub_power_ok, system_power_ok;
   logic controller_sleep_s4_enable, controller_deep_sleep_enable;
   logic [2:0] reset_threshold_sel, o;
   logic [7:0] regulator_enable, d;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   int t [3];
   // Offset, reset value, write value, read-back value
   logic [31:0] rows [7] = '{32'h4100a6a6, 32'h4200ff01, 32'h43008181, 32'h481ce505,
                             32'h49000000, 32'h44005a00, 32'h405fff7f};
   assign sda = !(sda_oe | sda_pull);
   assign o = {system_power_ok, platform_hub_power_ok, resume_reset_good};
   always #4 core_clk = ~core_clk;
   always #24 rtc_clk = ~rtc_clk;
   pgr_top pgr_top_inst (.core_clk, .srst, .rtc_srst, .scl, .sda_in(sda), .sda_out, .sda_oe,
      .rtc_clk, .always_on_good, .all_rails_good, .supply_low(1'h0), .rail_enable_pin,
      .regulator_voltage_ctrl, .resume_reset_good, .platform_hub_power_ok, .system_power_ok,
      .system_reset, .reset_threshold_sel, .regulator_ctrl_lock, .controller_sleep_s4_enable,
      .controller_deep_sleep_enable, .regulator_enable);
   pgr_ec_model pgr_ec_model_inst (.scl, .sda_pull, .sda);
   task automatic step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic span(input int v, input int lo, input int hi);
      check_count++;
      if (v < lo || v > hi) begin
         failures++;
         $display("ERROR at %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      step(5);
      srst = 1'h0;
      rtc_srst = 1'h0;
      step(4);
      for (int i = 0; i < 7; i++) begin
         pgr_ec_model_inst.rd(rows[i][31:24], d);
         check(d, rows[i][23:16]);
         pgr_ec_model_inst.wr(rows[i][31:24], rows[i][15:8]);
         pgr_ec_model_inst.rd(rows[i][31:24], d);
         check(d, rows[i][7:0]);
      end
      check({5'h0, reset_threshold_sel}, 8'h05);
      check({7'h0, regulator_ctrl_lock}, 8'h01);
      check({6'h0, controller_sleep_s4_enable, controller_deep_sleep_enable}, 8'h02);
      check({7'h0, system_reset}, 8'h00);
      check(regulator_enable, 8'hbd);
      rail_enable_pin = 8'hff;
      regulator_voltage_ctrl = 8'h00;
      step(6);
      check(regulator_enable, 8'h7e);
      // Foreign address must be refused and leave registers alone
      pgr_ec_model_inst.dev = 7'h2b;
      pgr_ec_model_inst.wr(OFF_SLEEP_ENABLE_CTRL, 8'h00);
      check({7'h0, pgr_ec_model_inst.nak}, 8'h01);
      pgr_ec_model_inst.dev = 7'h2a;
      pgr_ec_model_inst.rd(OFF_SLEEP_ENABLE_CTRL, d);
      check(d, 8'ha6);
      pgr_ec_model_inst.wr(OFF_PGD, 8'h01);
      step(1);
      always_on_good = 1'h1;
      all_rails_good = 1'h1;
      t = '{0, 0, 0};
      for (n = 1; n < 1100; n++) begin
         step(1);
         for (int k = 0; k < 3; k++) begin
            if (o[k] === 1'h1 && t[k] == 0) begin
               t[k] = n;
            end
         end
      end
      span(t[0], 1, 8);
      span(t[1], 81 * TK, 84 * TK + 8);
      span(t[2], 163 * TK, 166 * TK + 8);
      all_rails_good = 1'h0;
      step(6);
      check({5'h0, o}, 8'h01);
      // Hold code 0 is 656 slow periods; the write's tail eats a few cycles
      pgr_ec_model_inst.wr(OFF_FORCED_SHUTDOWN, 8'h01);
      check({7'h0, system_reset}, 8'h01);
      for (n = 0; n < 5000 && system_reset === 1'h1; n++) begin
         step(1);
      end
      span(n, 650 * TK, 657 * TK);
      pgr_ec_model_inst.rd(OFF_FORCED_SHUTDOWN, d);
      check(d, 8'h00);
      srst = 1'h1;
      step(5);
      srst = 1'h0;
      step(4);
      pgr_ec_model_inst.rd(OFF_RSTC, d);
      check(d, 8'h05);
      pgr_ec_model_inst.rd(OFF_PGD, d);
      check(d, 8'h5f);
      wrap_up();
   end
endmodule // tb_top
